// >>> rtl/mlsc_pkg.sv
// Purpose: constants for the motor limit and sensor control block
// Assumes: one 100 MHz clock, synchronous active-low reset
// Notes: register map reached over a plain address/strobe port
package mlsc_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int ADC_W = 10;
  localparam int POS_W = 24;
  localparam int NFLT = 6;
  // register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STAT = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_FAULT = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_ANPOS = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_SNPOS = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h6;
  // control fields
  localparam int CTL_FWD_NC = 0;
  localparam int CTL_REV_NC = 1;
  localparam int CTL_FWD_OFF = 2;
  localparam int CTL_REV_OFF = 3;
  localparam int CTL_SENS_LO = 4;
  localparam int CTL_DRV_EN = 6;
  // fault bit positions
  localparam int FLT_FWD_LIM = 0;
  localparam int FLT_REV_LIM = 1;
  localparam int FLT_FWD_SOFT = 2;
  localparam int FLT_REV_SOFT = 3;
  localparam int FLT_UNDER_V = 4;
  localparam int FLT_OVER_T = 5;
  localparam int FLT_STICKY_LO = 8;
  // interrupt event bits
  localparam int EV_FAULT = 0;
  localparam int EV_CAN_ERR = 1;
  localparam int EV_FRAME = 2;
  localparam int NEV = 3;
  // timing
  localparam int CLK_MHZ = 100;
  localparam int BLANK_US = 10;
  localparam int BLANK_CYC = BLANK_US * CLK_MHZ;
  localparam int FRAME_PERIOD_US = 1000;
  localparam int FRAME_CYC = FRAME_PERIOD_US * CLK_MHZ;
  localparam logic [ADC_W-1:0] ADC_MAX = 10'h3FF;
  localparam logic [ADC_W-1:0] ADC_HIGH = 10'h300;
  localparam logic [ADC_W-1:0] ADC_LOW = 10'h0FF;
  typedef enum logic [1:0] {
    MLSC_SENS_QUAD = 2'h0,
    MLSC_SENS_POT = 2'h1,
    MLSC_SENS_ANENC = 2'h2
  } mlsc_sens_t;
  typedef enum logic [2:0] {
    MLSC_RUN = 3'b001,
    MLSC_BLANK = 3'b010,
    MLSC_FAULT = 3'b100
  } mlsc_drv_t;
endpackage

// >>> rtl/mlsc_top.sv
// Purpose: limit switch, fault flag and feedback position logic of a motor controller
// Assumes: inputs synchronous to REF_CLK; CAN core reports frame events as pulses
// Notes: persistent store modelled as a load/save port to an external nonvolatile memory
`timescale 1ns/1ps
`default_nettype none
module mlsc_top
  import mlsc_pkg::*;
#(
  parameter int BLANK_CYCLES = mlsc_pkg::BLANK_CYC
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [mlsc_pkg::ADDR_W-1:0] ADDR,
  input wire logic [mlsc_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [mlsc_pkg::DATA_W-1:0] RDATA,
  input wire logic FWD_LIM_PIN,
  input wire logic REV_LIM_PIN,
  input wire logic FWD_SOFT_HIT,
  input wire logic REV_SOFT_HIT,
  input wire logic UNDER_V,
  input wire logic OVER_T,
  input wire logic [mlsc_pkg::ADC_W-1:0] ADC_CODE,
  input wire logic ADC_VALID,
  input wire logic [1:0] NV_POL,
  input wire logic NV_VALID,
  output logic [1:0] NV_POL_WR,
  output logic NV_SAVE,
  input wire logic CAN_MALFORMED,
  input wire logic CAN_FRAME,
  output logic CAN_ERR_TX,
  output logic DRIVE_EN,
  output logic FWD_ALLOWED,
  output logic REV_ALLOWED,
  output logic IRQ
);
  import mlsc_pkg::*;

  // blanking counter is 16 bits wide
  if (BLANK_CYCLES < 1 || BLANK_CYCLES > 65535) begin : g_blank_chk
    $error("BLANK_CYCLES out of range");
  end

  // ****************************************
  // control register
  // ****************************************
  logic [1:0] pol_q;
  logic [1:0] off_q;
  mlsc_sens_t sens_q;
  logic drv_req_q;
  logic wr_ctrl;
  logic pol_change;
  assign wr_ctrl = WR && ADDR == OFS_CTRL;
  assign pol_change = wr_ctrl && WDATA[CTL_REV_NC:CTL_FWD_NC] != pol_q;

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      off_q <= 2'h0;
      sens_q <= MLSC_SENS_QUAD;
      drv_req_q <= 1'b0;
    end else if (wr_ctrl) begin
      off_q <= WDATA[CTL_REV_OFF:CTL_FWD_OFF];
      sens_q <= mlsc_sens_t'(WDATA[CTL_SENS_LO+1:CTL_SENS_LO]);
      drv_req_q <= WDATA[CTL_DRV_EN];
    end
  end

  // polarity loaded from the persistent store, saved on change
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      pol_q <= 2'h0;
      NV_POL_WR <= 2'h0;
      NV_SAVE <= 1'b0;
    end else begin
      NV_SAVE <= pol_change;
      if (pol_change) begin
        pol_q <= WDATA[CTL_REV_NC:CTL_FWD_NC];
        NV_POL_WR <= WDATA[CTL_REV_NC:CTL_FWD_NC];
      end else if (NV_VALID) begin
        pol_q <= NV_POL;
      end
    end
  end

  // ****************************************
  // limit logic and drive state
  // ****************************************
  logic [1:0] pin_raw;
  logic [1:0] closed;
  logic [1:0] lim_hit;
  assign pin_raw = {REV_LIM_PIN, FWD_LIM_PIN};
  assign closed = pin_raw ^ pol_q;
  assign lim_hit = closed & ~off_q;

  mlsc_drv_t drv_q;
  logic [15:0] blank_cnt_q;
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      drv_q <= MLSC_RUN;
      blank_cnt_q <= 16'h0000;
    end else begin
      unique case (drv_q)
        MLSC_RUN: begin
          if (pol_change) begin
            drv_q <= MLSC_BLANK;
            blank_cnt_q <= 16'(BLANK_CYCLES - 1);
          end
        end
        MLSC_BLANK: begin
          if (pol_change) begin
            blank_cnt_q <= 16'(BLANK_CYCLES - 1);
          end else if (blank_cnt_q == 16'h0000) begin
            drv_q <= MLSC_RUN;
          end else begin
            blank_cnt_q <= blank_cnt_q - 16'h0001;
          end
        end
        default: begin
          drv_q <= MLSC_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      DRIVE_EN <= 1'b0;
      FWD_ALLOWED <= 1'b0;
      REV_ALLOWED <= 1'b0;
    end else begin
      DRIVE_EN <= drv_req_q && drv_q == MLSC_RUN && !pol_change;
      FWD_ALLOWED <= !lim_hit[0] && !FWD_SOFT_HIT;
      REV_ALLOWED <= !lim_hit[1] && !REV_SOFT_HIT;
    end
  end

  // ****************************************
  // fault flags
  // ****************************************
  logic [NFLT-1:0] flt_now;
  logic [NFLT-1:0] flt_q;
  logic [NFLT-1:0] sticky_q;
  logic wr_fault;
  assign flt_now = {OVER_T, UNDER_V, REV_SOFT_HIT, FWD_SOFT_HIT, lim_hit};
  assign wr_fault = WR && ADDR == OFS_FAULT;

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      flt_q <= '0;
      sticky_q <= '0;
    end else begin
      flt_q <= flt_now;
      // set wins over a write-one clear
      sticky_q <= (sticky_q & ~(wr_fault ? WDATA[FLT_STICKY_LO+NFLT-1:FLT_STICKY_LO] : '0))
        | flt_now;
    end
  end

  // ****************************************
  // analog and sensor positions
  // ****************************************
  logic [ADC_W-1:0] adc_prev_q;
  logic [POS_W-1:0] an_pos_q;
  logic [POS_W-1:0] sn_pos_q;
  logic [POS_W-1:0] an_next;
  logic wrap_up;
  logic wrap_dn;
  assign wrap_up = adc_prev_q > ADC_HIGH && ADC_CODE < ADC_LOW;
  assign wrap_dn = adc_prev_q < ADC_LOW && ADC_CODE > ADC_HIGH;

  always_comb begin
    an_next = {an_pos_q[POS_W-1:ADC_W], ADC_CODE};
    if (sens_q == MLSC_SENS_ANENC && wrap_up) begin
      an_next = {an_pos_q[POS_W-1:ADC_W] + (POS_W-ADC_W)'(1), ADC_CODE};
    end else if (sens_q == MLSC_SENS_ANENC && wrap_dn) begin
      an_next = {an_pos_q[POS_W-1:ADC_W] - (POS_W-ADC_W)'(1), ADC_CODE};
    end else if (sens_q != MLSC_SENS_ANENC) begin
      an_next = {(POS_W-ADC_W)'(0), ADC_CODE};
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      adc_prev_q <= '0;
      an_pos_q <= '0;
    end else if (ADC_VALID) begin
      adc_prev_q <= ADC_CODE;
      an_pos_q <= an_next;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      sn_pos_q <= '0;
    end else if (WR && ADDR == OFS_SNPOS) begin
      sn_pos_q <= WDATA[POS_W-1:0];
    end else if (sens_q == MLSC_SENS_POT) begin
      sn_pos_q <= {(POS_W-ADC_W)'(0), an_pos_q[ADC_W-1:0]};
    end else if (sens_q == MLSC_SENS_ANENC) begin
      sn_pos_q <= an_pos_q;
    end
  end

  // ****************************************
  // CAN error frame output
  // ****************************************
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      CAN_ERR_TX <= 1'b0;
    end else begin
      CAN_ERR_TX <= CAN_MALFORMED;
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  logic [NEV-1:0] ev;
  logic [NEV-1:0] irq_stat_q;
  logic [NEV-1:0] irq_mask_q;
  assign ev[EV_FAULT] = |(flt_now & ~flt_q);
  assign ev[EV_CAN_ERR] = CAN_MALFORMED;
  assign ev[EV_FRAME] = CAN_FRAME;

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      IRQ <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~((WR && ADDR == OFS_IRQ_STAT) ? WDATA[NEV-1:0] : '0)) | ev;
      if (WR && ADDR == OFS_IRQ_MASK) begin
        irq_mask_q <= WDATA[NEV-1:0];
      end
      IRQ <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ****************************************
  // read port
  // ****************************************
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      RDATA <= '0;
    end else if (RD) begin
      unique case (ADDR)
        OFS_CTRL: RDATA <= DATA_W'({drv_req_q, sens_q, off_q, pol_q});
        OFS_STAT: RDATA <= DATA_W'({drv_q == MLSC_RUN, off_q, pin_raw});
        OFS_FAULT: RDATA <= DATA_W'({sticky_q, 2'h0, flt_q});
        OFS_ANPOS: RDATA <= DATA_W'(an_pos_q);
        OFS_SNPOS: RDATA <= DATA_W'(sn_pos_q);
        OFS_IRQ_STAT: RDATA <= DATA_W'(irq_stat_q);
        OFS_IRQ_MASK: RDATA <= DATA_W'(irq_mask_q);
        default: RDATA <= '0;
      endcase
    end else begin
      RDATA <= '0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_pol_blank: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    pol_change |=> !DRIVE_EN [*2]) else $error("drive not off after polarity change");
  a_blank_end: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    drv_q == MLSC_BLANK && blank_cnt_q == 16'h0000 && !pol_change |=> drv_q == MLSC_RUN)
    else $error("blanking did not end");
  a_override_keeps: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    wr_ctrl && !pol_change && WDATA[CTL_DRV_EN] && drv_q == MLSC_RUN
    |=> pol_change or ##1 DRIVE_EN)
    else $error("override dropped drive");
  a_drive_req: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    !drv_req_q |=> !DRIVE_EN) else $error("drive without request");
  a_pol_saved: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    pol_change |=> NV_SAVE && NV_POL_WR == pol_q) else $error("polarity not saved");
  a_pol_hold: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    !pol_change && !NV_VALID |=> $stable(pol_q)) else $error("polarity changed unasked");
  a_pot_pos: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    sens_q == MLSC_SENS_POT && $stable(sens_q) && !(WR && ADDR == OFS_SNPOS)
    |=> sn_pos_q == {(POS_W-ADC_W)'(0), $past(an_pos_q[ADC_W-1:0])})
    else $error("pot position mismatch");
  a_adc_low: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    ADC_VALID |=> an_pos_q[ADC_W-1:0] == $past(ADC_CODE)) else $error("adc bits wrong");
  a_sn_write: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    WR && ADDR == OFS_SNPOS |=> sn_pos_q == $past(WDATA[POS_W-1:0]))
    else $error("sensor write lost");
  a_forced_off: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    off_q[0] && !FWD_SOFT_HIT |=> FWD_ALLOWED && !flt_q[FLT_FWD_LIM])
    else $error("forced-off limit acted");
  a_rev_forced: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    off_q[1] && !REV_SOFT_HIT |=> REV_ALLOWED && !flt_q[FLT_REV_LIM])
    else $error("forced-off reverse limit acted");
  a_fwd_limit: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    lim_hit[0] |=> !FWD_ALLOWED && flt_q[FLT_FWD_LIM] && sticky_q[FLT_FWD_LIM])
    else $error("forward limit not flagged");
  a_rev_limit: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    lim_hit[1] |=> !REV_ALLOWED && flt_q[FLT_REV_LIM] && sticky_q[FLT_REV_LIM])
    else $error("reverse limit not flagged");
  a_soft_fwd: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    FWD_SOFT_HIT |=> !FWD_ALLOWED && flt_q[FLT_FWD_SOFT] && sticky_q[FLT_FWD_SOFT])
    else $error("forward soft limit not flagged");
  a_soft_rev: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    REV_SOFT_HIT |=> !REV_ALLOWED && flt_q[FLT_REV_SOFT] && sticky_q[FLT_REV_SOFT])
    else $error("reverse soft limit not flagged");
  a_sticky_hold: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    sticky_q[FLT_UNDER_V] && !wr_fault |=> sticky_q[FLT_UNDER_V])
    else $error("sticky flag lost");
  a_sticky_clear: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    wr_fault && WDATA[FLT_STICKY_LO+FLT_UNDER_V] && !UNDER_V |=> !sticky_q[FLT_UNDER_V])
    else $error("sticky flag not cleared");
  a_sticky_set: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    UNDER_V |=> sticky_q[FLT_UNDER_V] && flt_q[FLT_UNDER_V]) else $error("fault not flagged");
  a_overtemp: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    OVER_T |=> sticky_q[FLT_OVER_T] && flt_q[FLT_OVER_T]) else $error("heat not flagged");
  a_err_frame: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CAN_MALFORMED |=> CAN_ERR_TX) else $error("no error frame");
  a_err_pulse: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    !CAN_MALFORMED |=> !CAN_ERR_TX) else $error("error frame without cause");
  a_frame_event: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CAN_FRAME |=> irq_stat_q[EV_FRAME]) else $error("frame event lost");
  a_irq_on: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    |(irq_stat_q & irq_mask_q) |=> IRQ) else $error("interrupt not raised");
  a_irq_off: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    !(|(irq_stat_q & irq_mask_q)) |=> !IRQ) else $error("interrupt without cause");
  a_stat_pins: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RD && ADDR == OFS_STAT |=> RDATA[1:0] == $past(pin_raw)) else $error("pin state wrong");
  a_unmapped_rd: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RD && ADDR > OFS_IRQ_MASK |=> RDATA == '0) else $error("unmapped read not zero");
  a_rdata_idle: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    !RD |=> RDATA == '0) else $error("read data outside read");
  a_wrap_up: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    ADC_VALID && sens_q == MLSC_SENS_ANENC && adc_prev_q == ADC_MAX && ADC_CODE == '0
    |=> an_pos_q == $past(an_pos_q) + POS_W'(1)) else $error("wrap not tracked");
  a_wrap_down: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    ADC_VALID && sens_q == MLSC_SENS_ANENC && adc_prev_q == '0 && ADC_CODE == ADC_MAX
    |=> an_pos_q == $past(an_pos_q) - POS_W'(1)) else $error("underflow not tracked");
endmodule
`default_nettype wire

// >>> verification/mlsc_host_model.sv
// Purpose: host side model issuing periodic control frames
// Assumes: one clock domain shared with the block
// Notes: frames only while run is high
`timescale 1ns/1ps
`default_nettype none
module mlsc_host_model #(
  parameter int PERIOD_CYC = mlsc_pkg::FRAME_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  output logic frame,
  output int sent
);
  import mlsc_pkg::*;
  int cnt;
  // one frame per period at most
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt <= 0;
      frame <= 1'b0;
      sent <= 0;
    end else begin
      frame <= 1'b0;
      if (run) begin
        if (cnt == PERIOD_CYC - 1) begin
          cnt <= 0;
          frame <= 1'b1;
          sent <= sent + 1;
        end else begin
          cnt <= cnt + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/mlsc_top_tb.sv
// Purpose: self-checking bench for the limit and sensor block
// Assumes: blanking shortened to 4 cycles, frame period 200 cycles
// Notes: register access through the plain strobe port
`timescale 1ns/1ps
`default_nettype none
module mlsc_top_tb;
  import mlsc_pkg::*;
  logic REF_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [ADDR_W-1:0] ADDR = '0;
  logic [DATA_W-1:0] WDATA = '0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [DATA_W-1:0] RDATA;
  logic FWD_LIM_PIN = 1'b0;
  logic REV_LIM_PIN = 1'b0;
  logic FWD_SOFT_HIT = 1'b0;
  logic REV_SOFT_HIT = 1'b0;
  logic UNDER_V = 1'b0;
  logic OVER_T = 1'b0;
  logic [ADC_W-1:0] ADC_CODE = '0;
  logic ADC_VALID = 1'b0;
  logic [1:0] NV_POL = 2'h0;
  logic NV_VALID = 1'b0;
  logic [1:0] NV_POL_WR;
  logic NV_SAVE;
  logic CAN_MALFORMED = 1'b0;
  logic CAN_FRAME;
  logic CAN_ERR_TX, DRIVE_EN, FWD_ALLOWED, REV_ALLOWED, IRQ;
  logic run = 1'b0;
  logic [1:0] nv_saved = 2'h0;
  logic [31:0] d;
  logic last_de;
  int sent, lows, cyc = 0;
  int err_count = 0;
  int total_checks = 0;
  mlsc_top #(.BLANK_CYCLES(4)) mlsc_top_i (.REF_CLK(REF_CLK), .RST_N(RST_N), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .FWD_LIM_PIN(FWD_LIM_PIN),
    .REV_LIM_PIN(REV_LIM_PIN), .FWD_SOFT_HIT(FWD_SOFT_HIT), .REV_SOFT_HIT(REV_SOFT_HIT),
    .UNDER_V(UNDER_V), .OVER_T(OVER_T), .ADC_CODE(ADC_CODE), .ADC_VALID(ADC_VALID),
    .NV_POL(NV_POL), .NV_VALID(NV_VALID), .NV_POL_WR(NV_POL_WR), .NV_SAVE(NV_SAVE),
    .CAN_MALFORMED(CAN_MALFORMED), .CAN_FRAME(CAN_FRAME), .CAN_ERR_TX(CAN_ERR_TX),
    .DRIVE_EN(DRIVE_EN), .FWD_ALLOWED(FWD_ALLOWED), .REV_ALLOWED(REV_ALLOWED), .IRQ(IRQ));
  mlsc_host_model #(.PERIOD_CYC(200)) mlsc_host_model_i (.clk(REF_CLK), .rst_n(RST_N),
    .run(run), .frame(CAN_FRAME), .sent(sent));
  // ****************************************
  // clock, timeout, store capture
  // ****************************************
  always #5 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) begin
    cyc++;
    if (NV_SAVE === 1'b1) nv_saved <= NV_POL_WR;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge REF_CLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge REF_CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge REF_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge REF_CLK);
    RD <= 1'b0;
    #1;
    v = RDATA;
  endtask
  task automatic set_pls(input int k, input logic v);
    case (k)
      0: ADC_VALID <= v;
      1: NV_VALID <= v;
      2: FWD_SOFT_HIT <= v;
      default: CAN_MALFORMED <= v;
    endcase
  endtask
  // one-cycle pulse: 0 adc valid, 1 store valid, 2 fwd soft hit, 3 can malformed
  task automatic pulse(input int k);
    @(posedge REF_CLK);
    set_pls(k, 1'b1);
    @(posedge REF_CLK);
    set_pls(k, 1'b0);
  endtask
  task automatic adc(input logic [9:0] c);
    @(posedge REF_CLK);
    ADC_CODE <= c;
    pulse(0);
    step(3);
  endtask
  task automatic watch(input int n);
    lows = 0;
    repeat (n) begin
      step(1);
      if (DRIVE_EN !== 1'b1) lows++;
    end
    last_de = DRIVE_EN;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    step(4);
    RST_N <= 1'b1;
    rd(4'hF, d); chk("unmapped", d, 32'h0);
    step(1); chk("rdata idle", RDATA, 32'h0);
    wr(OFS_CTRL, 32'h40); step(4); chk("drive on", DRIVE_EN, 1'b1);
    fork wr(OFS_CTRL, 32'h4C); watch(10); join
    chk("override keeps drive", lows, 0);
    FWD_LIM_PIN <= 1'b1; REV_LIM_PIN <= 1'b1; step(3);
    rd(OFS_STAT, d); chk("status", d[4:0], 5'h1F);
    rd(OFS_FAULT, d); chk("forced off no fault", d, 32'h0);
    chk("forced off allowed", FWD_ALLOWED, 1'b1);
    chk("rev forced off allowed", REV_ALLOWED, 1'b1);
    wr(OFS_CTRL, 32'h40); step(4);
    chk("limit blocks", FWD_ALLOWED, 1'b0);
    chk("rev limit blocks", REV_ALLOWED, 1'b0);
    rd(OFS_FAULT, d); chk("limit faults", d, 32'h303);
    FWD_LIM_PIN <= 1'b0; REV_LIM_PIN <= 1'b0; step(3);
    rd(OFS_FAULT, d); chk("sticky held", d, 32'h300);
    chk("rev free", REV_ALLOWED, 1'b1);
    wr(OFS_FAULT, 32'h300); rd(OFS_FAULT, d); chk("sticky clr", d, 32'h0);
    wr(OFS_CTRL, 32'h4C); step(12);
    fork wr(OFS_CTRL, 32'h4D); watch(16); join
    chk("blanked", lows != 0, 1'b1);
    chk("resumed", last_de, 1'b1);
    chk("saved pol", nv_saved, 2'h1);
    NV_POL <= 2'h2; pulse(1); step(12);
    rd(OFS_CTRL, d); chk("loaded pol", d[6:0], 7'h4E);
    wr(OFS_CTRL, 32'h5C); adc(10'h2A5);
    rd(OFS_ANPOS, d); chk("analog raw", d[9:0], 10'h2A5);
    rd(OFS_SNPOS, d); chk("pot sensor", d, 32'h2A5);
    wr(OFS_CTRL, 32'h4C); wr(OFS_SNPOS, 32'h123456); step(2);
    rd(OFS_SNPOS, d); chk("sensor set", d[23:0], 24'h123456);
    wr(OFS_CTRL, 32'h6C); adc(10'h3FF); adc(10'h000);
    rd(OFS_ANPOS, d); chk("wrap up", d[23:0], 24'h400);
    adc(10'h3FF);
    rd(OFS_ANPOS, d); chk("wrap down", d[23:0], 24'h3FF);
    for (int i = 2; i < 6; i++) begin
      {OVER_T, UNDER_V, REV_SOFT_HIT, FWD_SOFT_HIT} <= 4'h1 << (i - 2);
      step(3);
      rd(OFS_FAULT, d);
      chk("fault now", d, (32'h1 << i) | (32'h3C00 & ~(32'hFFFF << (i + 9))));
    end
    {OVER_T, UNDER_V, REV_SOFT_HIT, FWD_SOFT_HIT} <= 4'h0; step(3);
    rd(OFS_FAULT, d); chk("sticky all", d, 32'h3C00);
    wr(OFS_FAULT, 32'h3F00); wr(OFS_IRQ_MASK, 32'h0); wr(OFS_IRQ_STAT, 32'h7);
    pulse(2); step(3);
    chk("irq masked", IRQ, 1'b0);
    rd(OFS_IRQ_STAT, d); chk("irq fault ev", d, 32'h1);
    wr(OFS_IRQ_MASK, 32'h7); step(3); chk("irq on", IRQ, 1'b1);
    wr(OFS_IRQ_STAT, 32'h1); step(3); chk("irq clr", IRQ, 1'b0);
    pulse(3); #1; chk("error frame", CAN_ERR_TX, 1'b1);
    step(2); rd(OFS_IRQ_STAT, d); chk("can err ev", d, 32'h2);
    wr(OFS_IRQ_STAT, 32'h2);
    run <= 1'b1; step(450); run <= 1'b0; step(2);
    rd(OFS_IRQ_STAT, d); chk("frame ev", d, 32'h4);
    chk("frames sent", sent, 32'h2);
    end_sim();
  end
endmodule
`default_nettype wire
